// file: rtl/lsr_cmd.sv
// LED controller command handling: status readback and display memory write
`timescale 1ns/10ps
`default_nettype none

// Parameterised FIFO between the byte source and the command decoder
module lsr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             REF_CLK,
  input  wire logic             NRST,
  input  wire logic             IN_VALID,
  input  wire logic [WIDTH-1:0] IN_DATA,
  output logic                  IN_READY,
  output logic                  OUT_VALID,
  output logic      [WIDTH-1:0] OUT_DATA,
  input  wire logic             OUT_READY
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } lsr_fifo_s;

  lsr_fifo_s             r;
  lsr_fifo_s             next_r;
  logic      [WIDTH-1:0] mem [DEPTH];
  logic                  push;
  logic                  pop;

  // Refuse sizes the pointer logic cannot serve, at elaboration rather than at run time
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("lsr_fifo: DEPTH must be >= 2, WIDTH >= 1");
  end

  // Honest full and empty straight from the count
  assign IN_READY  = (r.count != (AW+1)'(DEPTH));
  assign OUT_VALID = (r.count != '0);
  assign OUT_DATA  = mem[r.rd_ptr];
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;

  // Pointer and count update, wrapping at DEPTH for non power of two sizes
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.wr_ptr = (r.wr_ptr == AW'(DEPTH - 1)) ? '0 : r.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_r.rd_ptr = (r.rd_ptr == AW'(DEPTH - 1)) ? '0 : r.rd_ptr + 1'b1;
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Storage has no reset; empty entries are never presented
  always_ff @(posedge REF_CLK) begin
    if (push) begin
      mem[r.wr_ptr] <= IN_DATA;
    end
  end
endmodule : lsr_fifo

module lsr_cmd
  import lsr_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // Incoming command/data bytes from the serial transport
  input  wire logic        RX_VALID,
  input  wire logic        RX_FIRST,
  input  wire logic [7:0]  RX_DATA,
  output logic             RX_READY,
  // Readback bytes towards the serial transport
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  input  wire logic        TX_READY,
  // Current settings held by the other command handlers
  input  wire logic        PIXEL_MODE_SELECT,
  input  wire logic        SCAN_POLARITY_TYPE,
  input  wire logic [2:0]  COM_COUNT,
  input  wire logic        BLANK_TYPE_SELECT,
  input  wire logic [1:0]  BLANK_TIME,
  input  wire logic [2:0]  CASCADE_ROLE,
  input  wire logic        OSCILLATOR_ON,
  input  wire logic        DISPLAY_ON,
  input  wire logic [2:0]  CURRENT_RATIO,
  input  wire logic [6:0]  GLOBAL_BRIGHTNESS,
  input  wire logic        THERMAL_SHUTDOWN_ENABLE,
  input  wire logic        THERMAL_SHUTDOWN_LATCH,
  input  wire logic        UNIVERSAL_SEGMENT_ENABLE,
  input  wire logic        MATRIX_MASK_ENABLE,
  input  wire logic        UNIVERSAL_COLUMN_ENABLE,
  input  wire logic        BLINK_ENABLE,
  input  wire logic        FADE_ENABLE,
  input  wire logic        SCROLL_ACTIVE,
  input  wire logic        VERTICAL_SCROLL_ENABLE,
  input  wire logic        HORIZONTAL_SCROLL_ENABLE,
  input  wire logic        VERTICAL_DIRECTION,
  input  wire logic        HORIZONTAL_DIRECTION,
  input  wire logic [3:0]  VERTICAL_SPEED,
  input  wire logic [3:0]  HORIZONTAL_SPEED,
  input  wire logic [7:0]  COLUMN_LINE_ON,
  input  wire logic [27:0] ROW_LINE_ON,
  input  wire logic [3:0]  DIRECT_PWM_SWITCH,
  input  wire logic [3:0]  DIRECT_PORT_SELECT,
  input  wire logic [6:0]  DIRECT_PWM_ROW24,
  input  wire logic [6:0]  DIRECT_PWM_ROW25,
  input  wire logic [6:0]  DIRECT_PWM_ROW26,
  input  wire logic [6:0]  DIRECT_PWM_ROW27,
  // Dot lookup from the scan engine
  input  wire logic [4:0]  DOT_ROW,
  input  wire logic [2:0]  DOT_COL,
  output logic             DOT_ON
);

  typedef struct packed {
    lsr_state_e                    st;
    logic [IDX_W-1:0]              idx;
    logic [7:0]                    addr;
    logic                          tx_valid;
    logic [7:0]                    tx_data;
    logic [GRAY_BITS-1:0]          pwm_cnt;
    logic                          dot_on;
    logic [STATUS_BYTES-1:0][7:0]  stat;
  } lsr_cmd_s;

  // Reset image of the status bytes
  localparam logic [STATUS_BYTES-1:0][7:0] STAT_RESET = {
    {(STATUS_BYTES - SB_BRIGHTNESS - 1){RST_ZERO}},
    RST_BRIGHTNESS, RST_ZERO, RST_ZERO, RST_ZERO, RST_BLANKING, RST_SCAN_TYPE, RST_ZERO
  };

  lsr_cmd_s                    r;
  lsr_cmd_s                    next_r;
  logic     [7:0]              disp_mem [DISP_DEPTH];
  logic     [STATUS_BYTES-1:0][7:0] stat_now;
  logic                        f_valid;
  logic     [8:0]              f_data;
  logic                        f_ready;
  logic                        pop;
  logic                        mem_we;
  logic     [7:0]              mem_wa;
  logic     [7:0]              mem_wd;
  logic     [7:0]              dot_addr;
  logic     [7:0]              row_word;
  logic     [7:0]              gray_word;
  logic                        gray_mode;

  // Elaboration checks: FIFO size and one gray step per clock
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("lsr_cmd: FIFO_DEPTH must be at least 2");
  end
  if (PWM_TICK_CYCLES != 1) begin : g_bad_tick
    $error("lsr_cmd: gray counter assumes one tick per clock");
  end

  // The first-byte flag travels with its byte so a frame edge never overtakes queued data
  lsr_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .REF_CLK   (REF_CLK),
    .NRST      (NRST),
    .IN_VALID  (RX_VALID),
    .IN_DATA   ({RX_FIRST, RX_DATA}),
    .IN_READY  (RX_READY),
    .OUT_VALID (f_valid),
    .OUT_DATA  (f_data),
    .OUT_READY (f_ready)
  );

  // Draining stalls during readback, so a slow TX side backs up into the FIFO
  assign f_ready = (r.st != ST_STATUS);
  assign pop     = f_valid && f_ready;

  // Live status image; reserved and don't-care bits read as zero
  always_comb begin
    stat_now                  = '0;
    stat_now[SB_PIXEL_MODE]   = {7'h00, PIXEL_MODE_SELECT};
    stat_now[SB_SCAN_TYPE]    = {SCAN_POLARITY_TYPE, 4'h0, COM_COUNT};
    stat_now[SB_BLANKING]     = {BLANK_TYPE_SELECT, 5'h00, BLANK_TIME};
    stat_now[SB_CASCADE]      = {5'h00, CASCADE_ROLE};
    stat_now[SB_SYSTEM][POS_OSCILLATOR_ON] = OSCILLATOR_ON;
    stat_now[SB_SYSTEM][POS_DISPLAY_ON]    = DISPLAY_ON;
    stat_now[SB_CURRENT]      = {5'h00, CURRENT_RATIO};
    stat_now[SB_BRIGHTNESS]   = {1'b0, GLOBAL_BRIGHTNESS};
    stat_now[SB_FUNCTION]     = {THERMAL_SHUTDOWN_ENABLE, THERMAL_SHUTDOWN_LATCH, 1'b0,
                                 UNIVERSAL_SEGMENT_ENABLE, MATRIX_MASK_ENABLE,
                                 UNIVERSAL_COLUMN_ENABLE, BLINK_ENABLE, FADE_ENABLE};
    stat_now[SB_SCROLL_STATE] = {SCROLL_ACTIVE, 1'b0, VERTICAL_SCROLL_ENABLE,
                                 HORIZONTAL_SCROLL_ENABLE, 2'b00,
                                 VERTICAL_DIRECTION, HORIZONTAL_DIRECTION};
    stat_now[SB_SCROLL_SPEED] = {VERTICAL_SPEED, HORIZONTAL_SPEED};
    stat_now[SB_COLUMN]       = COLUMN_LINE_ON;
    stat_now[SB_ROW_HI]       = ROW_LINE_ON[27:20];
    stat_now[SB_ROW_MIDHI]    = ROW_LINE_ON[19:12];
    stat_now[SB_ROW_MIDLO]    = ROW_LINE_ON[11:4];
    stat_now[SB_ROW_LO]       = {4'h0, ROW_LINE_ON[3:0]};
    // Bit 7 is row 24 and bit 4 row 27, likewise for the select nibble
    stat_now[SB_DIRECT_CFG]   = {DIRECT_PWM_SWITCH[0], DIRECT_PWM_SWITCH[1],
                                 DIRECT_PWM_SWITCH[2], DIRECT_PWM_SWITCH[3],
                                 DIRECT_PORT_SELECT[0], DIRECT_PORT_SELECT[1],
                                 DIRECT_PORT_SELECT[2], DIRECT_PORT_SELECT[3]};
    stat_now[SB_DPWM_ROW27]   = {1'b0, DIRECT_PWM_ROW27};
    stat_now[SB_DPWM_ROW26]   = {1'b0, DIRECT_PWM_ROW26};
    stat_now[SB_DPWM_ROW25]   = {1'b0, DIRECT_PWM_ROW25};
    stat_now[SB_DPWM_ROW24]   = {1'b0, DIRECT_PWM_ROW24};
  end

  // Display lookup: binary uses one word per row, gray one byte per dot
  assign gray_mode = (r.stat[SB_PIXEL_MODE][POS_GRAY_SELECT] == 1'b0);
  assign dot_addr  = {DOT_ROW, DOT_COL};
  assign row_word  = (DOT_ROW < 5'd28) ? disp_mem[{3'b000, DOT_ROW}] : 8'h00;
  assign gray_word = (dot_addr < 8'(DISP_DEPTH)) ? disp_mem[dot_addr] : 8'h00;

  // Command decoder, readback sequencer and gray counter
  always_comb begin
    next_r      = r;
    mem_we      = 1'b0;
    mem_wa      = r.addr;
    mem_wd      = f_data[7:0];
    // Snapshot refreshes every clock so each byte shows the setting at send time
    next_r.stat = stat_now;
    // Free-running 64-step counter, one step per system clock period
    next_r.pwm_cnt = r.pwm_cnt + 1'b1;
    if (gray_mode) begin
      next_r.dot_on = (gray_word[GRAY_BITS-1:0] > r.pwm_cnt);
    end else begin
      next_r.dot_on = row_word[DOT_COL];
    end

    if (r.st == ST_STATUS) begin
      if (r.tx_valid && TX_READY) begin
        if (r.idx == IDX_W'(STATUS_BYTES)) begin
          next_r.tx_valid = 1'b0;
          next_r.st       = ST_IGNORE;
        end else begin
          next_r.tx_data = r.stat[r.idx];
          next_r.idx     = r.idx + 1'b1;
        end
      end
    end else if (pop) begin
      if (f_data[8] || r.st == ST_CMD) begin
        unique case (f_data[7:0])
          CMD_READ_STATUS: begin
            next_r.st       = ST_STATUS;
            next_r.idx      = '0;
            next_r.tx_valid = 1'b1;
            next_r.tx_data  = DUMMY_BYTE;
          end
          CMD_WRITE_DISPLAY: begin
            next_r.st = ST_ADDR;
          end
          default: begin
            next_r.st = ST_IGNORE;
          end
        endcase
      end else begin
        unique case (r.st)
          ST_ADDR: begin
            next_r.addr = f_data[7:0];
            next_r.st   = ST_DATA;
          end
          ST_DATA: begin
            // Writes past the end of memory are dropped but still advance
            mem_we      = (r.addr < 8'(DISP_DEPTH));
            next_r.addr = r.addr + 1'b1;
          end
          default: begin
            next_r.st = r.st;
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      r          <= '0;
      r.st       <= ST_CMD;
      r.stat     <= STAT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Display memory keeps the whole byte; gray view masks it on read
  always_ff @(posedge REF_CLK) begin
    if (mem_we) begin
      disp_mem[mem_wa] <= mem_wd;
    end
  end

  assign TX_VALID = r.tx_valid;
  assign TX_DATA  = r.tx_data;
  assign DOT_ON   = r.dot_on;

endmodule : lsr_cmd
`default_nettype wire

// file: rtl/lsr_pkg.sv
// Package: command codes, status layout, reset values and timing of the LED command block
package lsr_pkg;

  // Command bytes
  localparam logic [7:0] CMD_READ_STATUS   = 8'h71;
  localparam logic [7:0] CMD_WRITE_DISPLAY = 8'h80;
  localparam logic [7:0] DUMMY_BYTE        = 8'h00;

  // Readback shape: dummy byte then this many status bytes
  localparam int STATUS_BYTES = 20;
  localparam int IDX_W        = 5;

  // Status byte positions (index 0 is the third byte of the transfer)
  localparam int SB_PIXEL_MODE   = 0;
  localparam int SB_SCAN_TYPE    = 1;
  localparam int SB_BLANKING     = 2;
  localparam int SB_CASCADE      = 3;
  localparam int SB_SYSTEM       = 4;
  localparam int SB_CURRENT      = 5;
  localparam int SB_BRIGHTNESS   = 6;
  localparam int SB_FUNCTION     = 7;
  localparam int SB_SCROLL_STATE = 8;
  localparam int SB_SCROLL_SPEED = 9;
  localparam int SB_COLUMN       = 10;
  localparam int SB_ROW_HI       = 11;
  localparam int SB_ROW_MIDHI    = 12;
  localparam int SB_ROW_MIDLO    = 13;
  localparam int SB_ROW_LO       = 14;
  localparam int SB_DIRECT_CFG   = 15;
  localparam int SB_DPWM_ROW27   = 16;
  localparam int SB_DPWM_ROW26   = 17;
  localparam int SB_DPWM_ROW25   = 18;
  localparam int SB_DPWM_ROW24   = 19;

  // Status reset values (all others are zero)
  localparam logic [7:0] RST_SCAN_TYPE  = 8'h07;
  localparam logic [7:0] RST_BLANKING   = 8'h80;
  localparam logic [7:0] RST_BRIGHTNESS = 8'h40;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // Field positions inside status bytes
  localparam int POS_SCAN_POLARITY   = 7;
  localparam int POS_BLANK_TYPE      = 7;
  localparam int POS_OSCILLATOR_ON   = 1;
  localparam int POS_DISPLAY_ON      = 0;
  localparam int POS_GRAY_SELECT     = 0;

  // Display memory and gray scale
  localparam int DISP_DEPTH = 224;
  localparam int GRAY_BITS  = 6;

  // Gray time unit is one system clock period
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int REF_CLK_PERIOD_NS = 10;
  localparam int PWM_TICK_CYCLES   = SYS_CLK_PERIOD_NS / REF_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DATA,
    ST_STATUS,
    ST_IGNORE
  } lsr_state_e;

endpackage : lsr_pkg

// file: sim/lsr_cmd_props.sv
// Checker for the readback stream and dot lookup
`timescale 1ns/10ps
`default_nettype none
module lsr_cmd_props (
  input wire logic       REF_CLK,
  input wire logic       NRST,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_READY,
  input wire logic       PIXEL_MODE_SELECT,
  input wire logic [4:0] DOT_ROW,
  input wire logic       DOT_ON
);
  logic [4:0] idx;

  // Byte index in a readback: 0 is the dummy, k is transfer byte k+2
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST)
      idx <= 5'h00;
    else if (!TX_VALID)
      idx <= 5'h00;
    else if (TX_READY)
      idx <= idx + 5'h01;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  // Reserved bits of the scan, system, ratio, brightness, low row and direct PWM bytes are checked, as they read zero whatever the settings are
  property p_dummy; TX_VALID && idx == 5'h00 |-> TX_DATA == 8'h00; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy byte");
  property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_len; TX_VALID && TX_READY && idx == 5'h14 |=> !TX_VALID; endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_scan; TX_VALID && idx == 5'h02 |-> TX_DATA[6:3] == 4'h0; endproperty
  a_scan: assert property (p_scan) else $error("scan byte");
  property p_sys; TX_VALID && idx == 5'h05 |-> TX_DATA[7:2] == 6'h00; endproperty
  a_sys: assert property (p_sys) else $error("system byte");
  property p_ratio; TX_VALID && idx == 5'h06 |-> TX_DATA[7:3] == 5'h00; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio byte");
  property p_bright; TX_VALID && idx == 5'h07 |-> !TX_DATA[7]; endproperty
  a_bright: assert property (p_bright) else $error("brightness byte");
  property p_rowlo; TX_VALID && idx == 5'h0f |-> TX_DATA[7:4] == 4'h0; endproperty
  a_rowlo: assert property (p_rowlo) else $error("low row byte");
  property p_dpwm; TX_VALID && idx >= 5'h11 && idx <= 5'h14 |-> !TX_DATA[7]; endproperty
  a_dpwm: assert property (p_dpwm) else $error("direct pwm byte");
  property p_dot; PIXEL_MODE_SELECT && DOT_ROW >= 5'd28 |=> !DOT_ON; endproperty
  a_dot: assert property (p_dot) else $error("dot past last row");
endmodule : lsr_cmd_props

bind lsr_cmd lsr_cmd_props u_props (.REF_CLK(REF_CLK), .NRST(NRST), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_READY(TX_READY), .PIXEL_MODE_SELECT(PIXEL_MODE_SELECT),
  .DOT_ROW(DOT_ROW), .DOT_ON(DOT_ON));
`default_nettype wire

// file: sim/lsr_cmd_tb.sv
// Self-checking bench for the LED command block
`timescale 1ns/10ps
`default_nettype none
module lsr_cmd_tb import lsr_pkg::*;;
  logic         REF_CLK, NRST, stall, stall_on;
  logic [127:0] cfg;
  logic [4:0]   dot_row;
  logic [2:0]   dot_col;
  logic [31:0]  seed;
  logic [7:0]   exp_q[$];
  logic [7:0]   bin[28];
  logic [7:0]   g[8];
  int           fails, comparisons, refused, cnt;
  wire logic    rx_valid, rx_first, rx_ready, tx_valid, tx_ready, dot_on;
  wire logic [7:0] rx_data, tx_data;

  lsr_host u_host (.REF_CLK(REF_CLK), .STALL(stall), .RX_READY(rx_ready), .RX_VALID(rx_valid),
    .RX_FIRST(rx_first), .RX_DATA(rx_data), .TX_READY(tx_ready));

  lsr_cmd #(.FIFO_DEPTH(8)) DUT (.REF_CLK(REF_CLK), .NRST(NRST), .RX_VALID(rx_valid),
    .RX_FIRST(rx_first), .RX_DATA(rx_data), .RX_READY(rx_ready), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .PIXEL_MODE_SELECT(cfg[0]),
    .SCAN_POLARITY_TYPE(cfg[1]), .COM_COUNT(cfg[4:2]), .BLANK_TYPE_SELECT(cfg[5]),
    .BLANK_TIME(cfg[7:6]), .CASCADE_ROLE(cfg[10:8]), .OSCILLATOR_ON(cfg[11]),
    .DISPLAY_ON(cfg[12]), .CURRENT_RATIO(cfg[15:13]), .GLOBAL_BRIGHTNESS(cfg[22:16]),
    .THERMAL_SHUTDOWN_ENABLE(cfg[29]), .THERMAL_SHUTDOWN_LATCH(cfg[28]),
    .UNIVERSAL_SEGMENT_ENABLE(cfg[27]), .MATRIX_MASK_ENABLE(cfg[26]),
    .UNIVERSAL_COLUMN_ENABLE(cfg[25]), .BLINK_ENABLE(cfg[24]), .FADE_ENABLE(cfg[23]),
    .SCROLL_ACTIVE(cfg[34]), .VERTICAL_SCROLL_ENABLE(cfg[33]),
    .HORIZONTAL_SCROLL_ENABLE(cfg[32]), .VERTICAL_DIRECTION(cfg[31]),
    .HORIZONTAL_DIRECTION(cfg[30]), .VERTICAL_SPEED(cfg[38:35]),
    .HORIZONTAL_SPEED(cfg[42:39]), .COLUMN_LINE_ON(cfg[50:43]), .ROW_LINE_ON(cfg[78:51]),
    .DIRECT_PWM_SWITCH(cfg[82:79]), .DIRECT_PORT_SELECT(cfg[86:83]),
    .DIRECT_PWM_ROW24(cfg[93:87]), .DIRECT_PWM_ROW25(cfg[100:94]),
    .DIRECT_PWM_ROW26(cfg[107:101]), .DIRECT_PWM_ROW27(cfg[114:108]),
    .DOT_ROW(dot_row), .DOT_COL(dot_col), .DOT_ON(dot_on));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  task automatic stop_test();
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Expected readback for the settings now on the inputs
  task automatic expect_status();
    logic [7:0] st[20];
    st = '{{7'h00, cfg[0]}, {cfg[1], 4'h0, cfg[4:2]}, {cfg[5], 5'h00, cfg[7:6]},
      {5'h00, cfg[10:8]}, {6'h00, cfg[11], cfg[12]}, {5'h00, cfg[15:13]}, {1'b0, cfg[22:16]},
      {cfg[29:28], 1'b0, cfg[27:23]}, {cfg[34], 1'b0, cfg[33:32], 2'b00, cfg[31:30]},
      {cfg[38:35], cfg[42:39]}, cfg[50:43], cfg[78:71], cfg[70:63], cfg[62:55],
      {4'h0, cfg[54:51]}, {cfg[79], cfg[80], cfg[81], cfg[82], cfg[83], cfg[84], cfg[85],
      cfg[86]}, {1'b0, cfg[114:108]}, {1'b0, cfg[107:101]}, {1'b0, cfg[100:94]},
      {1'b0, cfg[93:87]}};
    exp_q.push_back(DUMMY_BYTE);
    foreach (st[i])
      exp_q.push_back(st[i]);
  endtask : expect_status

  // Wait for the readback to finish and the FIFO to empty into memory
  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++)
      @(negedge REF_CLK);
    chk("drain", 8'h00, 8'(exp_q.size()));
    repeat (16) @(negedge REF_CLK);
  endtask : drain

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  // Random stalls on the readback side
  always @(posedge REF_CLK)
    stall <= stall_on && (xs() >= 32'h8000_0000);

  // Monitor: each accepted readback byte takes the oldest expectation
  always @(posedge REF_CLK) begin
    if (NRST === 1'b1 && rx_valid && rx_ready !== 1'b1)
      refused++;
    if (NRST === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0)
        chk("tx_extra", 8'h00, 8'hxx);
      else
        chk("tx_byte", exp_q.pop_front(), tx_data);
    end
  end

  // Watchdog, far beyond the thousand or so cycles the run needs
  initial begin
    #200us;
    chk("watchdog", 8'h00, 8'h01);
    stop_test();
  end

  initial begin
    seed = 32'd41977;
    {fails, comparisons, refused} = '0;
    {stall_on, dot_row, dot_col, NRST} = '0;
    cfg = '0;
    cfg[4:2] = 3'h7;
    cfg[5] = 1'b1;
    cfg[22:16] = 7'h40;
    repeat (10) @(posedge REF_CLK);
    @(negedge REF_CLK);
    NRST = 1'b1;
    // Reset-equivalent settings must read back as the reset table
    exp_q.push_back(8'h00);
    for (int i = 0; i < STATUS_BYTES; i++)
      exp_q.push_back(i == 1 ? 8'h07 : i == 2 ? 8'h80 : i == 6 ? 8'h40 : 8'h00);
    u_host.send(1'b1, CMD_READ_STATUS);
    u_host.rel();
    drain();
    // Random settings with stalls; the last one has a write queued behind it
    stall_on = 1'b1;
    for (int k = 0; k < 3; k++) begin
      cfg = {xs(), xs(), xs(), xs()};
      expect_status();
      u_host.send(1'b1, CMD_READ_STATUS);
      if (k == 2) begin
        u_host.send(1'b1, CMD_WRITE_DISPLAY);
        u_host.send(1'b0, 8'h00);
        foreach (bin[i]) begin
          bin[i] = 8'(xs());
          u_host.send(1'b0, bin[i]);
        end
      end
      u_host.rel();
      drain();
    end
    chk("refused", 8'h01, {7'h00, refused != 0});
    // An unknown command must leave memory alone
    u_host.send(1'b1, 8'h55);
    u_host.send(1'b0, 8'h00);
    u_host.send(1'b0, ~bin[0]);
    u_host.rel();
    stall_on = 1'b0;
    drain();
    cfg[0] = 1'b1;
    // The mode reaches the lookup through the one-cycle status snapshot
    @(negedge REF_CLK);
    for (int r = 0; r < 32; r++) begin
      for (int c = 0; c < 8; c++) begin
        dot_row = 5'(r);
        dot_col = 3'(c);
        @(negedge REF_CLK);
        chk("dot_bin", {7'h00, r < 28 && bin[r % 28][c]}, {7'h00, dot_on});
      end
    end
    // Gray dots of row five, with both extremes of the scale
    u_host.send(1'b1, CMD_WRITE_DISPLAY);
    u_host.send(1'b0, 8'h28);
    for (int c = 0; c < 8; c++) begin
      g[c] = 8'(xs());
      if (c == 0)
        g[c][5:0] = 6'h00;
      if (c == 7)
        g[c][5:0] = 6'h3f;
      u_host.send(1'b0, g[c]);
    end
    u_host.rel();
    drain();
    cfg[0] = 1'b0;
    for (int c = 0; c < 8; c++) begin
      dot_row = 5'd5;
      dot_col = 3'(c);
      @(negedge REF_CLK);
      cnt = 0;
      repeat (64) begin
        @(negedge REF_CLK);
        cnt += int'(dot_on === 1'b1);
      end
      chk("dot_gray", {2'b00, g[c][5:0]}, 8'(cnt));
    end
    stop_test();
  end
endmodule : lsr_cmd_tb
`default_nettype wire

// file: sim/lsr_host.sv
// Host model: offers command bytes and takes readback bytes
`timescale 1ns/10ps
`default_nettype none
module lsr_host (
  input  wire logic       REF_CLK,
  input  wire logic       STALL,
  input  wire logic       RX_READY,
  output logic            RX_VALID,
  output logic            RX_FIRST,
  output logic      [7:0] RX_DATA,
  output logic            TX_READY
);
  // Idle lines at time zero
  initial begin
    RX_VALID = 1'b0;
    RX_FIRST = 1'b0;
    RX_DATA  = 8'h00;
    TX_READY = 1'b1;
  end

  // A stall keeps the device's byte waiting
  always @(negedge REF_CLK)
    TX_READY <= ~STALL;

  // Called at a falling edge; holds the byte until the FIFO has room
  task automatic send(input logic first, input logic [7:0] data);
    RX_VALID = 1'b1;
    RX_FIRST = first;
    RX_DATA  = data;
    while (RX_READY !== 1'b1)
      @(negedge REF_CLK);
    @(negedge REF_CLK);
  endtask : send

  // Released lines show the inverse, so a stale byte never looks valid
  task automatic rel();
    RX_VALID = 1'b0;
    RX_FIRST = ~RX_FIRST;
    RX_DATA  = ~RX_DATA;
  endtask : rel
endmodule : lsr_host
`default_nettype wire
